// ==== src/accel_irq_pkg.sv ====
// Operation
// - combine and six-direction bits pick the mode
// - enabled axis above threshold raises request
// - enabled axis below threshold raises request
// - active flag set when any interrupt generated
// - six per-axis flags show which event occurred
// - first source register is read-only
// - reading first source clears flag and pin
// - latched source frozen until host reads it
// - seven-bit threshold, top bit zero, reset zero
// - seven-bit minimum duration in sample steps
// - second generator identical and independent
// - reading second source clears flag and pin
// - latch bit selects held or live request
// - pad select routes source, OR, ready, boot
package accel_irq_pkg;
    // register offsets
    localparam logic [7:0] ADDR_CFG1 = 8'h30;
    localparam logic [7:0] ADDR_SRC1 = 8'h31;
    localparam logic [7:0] ADDR_THS1 = 8'h32;
    localparam logic [7:0] ADDR_DUR1 = 8'h33;
    localparam logic [7:0] ADDR_CFG2 = 8'h34;
    localparam logic [7:0] ADDR_SRC2 = 8'h35;
    localparam logic [7:0] ADDR_THS2 = 8'h36;
    localparam logic [7:0] ADDR_DUR2 = 8'h37;
    // reset and filler values
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [6:0] FIELD7_RESET = 7'h00;
    localparam logic [5:0] FLAGS_NONE = 6'h00;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;
    localparam int NUM_GEN = 2;
    // interrupt modes {combine, six-direction}
    localparam logic [1:0] MODE_OR = 2'h0;
    localparam logic [1:0] MODE_MOVE = 2'h1;
    localparam logic [1:0] MODE_AND = 2'h2;
    localparam logic [1:0] MODE_POS = 2'h3;
    // pad routing codes
    localparam logic [1:0] PAD_OWN = 2'h0;
    localparam logic [1:0] PAD_EITHER = 2'h1;
    localparam logic [1:0] PAD_DRDY = 2'h2;
    localparam logic [1:0] PAD_BOOT = 2'h3;

    // configuration register layout, msb first
    typedef struct packed {
        logic andOrCombine;
        logic sixDirectionEnable;
        logic [5:0] enables; // z_above z_below y_above y_below x_above x_below
    } event_config_t;

    // source register layout, msb first
    typedef struct packed {
        logic zero;
        logic eventActiveFlag;
        logic [5:0] flags; // z_above z_below y_above y_below x_above x_below
    } event_source_t;

    // one acceleration sample, signed per axis
    typedef struct packed {
        logic signed [7:0] z;
        logic signed [7:0] y;
        logic signed [7:0] x;
    } accel_sample_t;

    // register port request
    typedef struct packed {
        logic wrEn;
        logic rdEn;
        logic [7:0] addr;
        logic [7:0] wrData;
    } reg_req_t;
endpackage

// ==== src/event_detect.sv ====
`timescale 1ns/1ps
module event_detect
    import accel_irq_pkg::*;
#(
    parameter int THR_W = 7
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // setup
    input wire event_config_t cfg,
    input wire logic [THR_W-1:0] threshold,
    // samples
    input wire accel_sample_t sample,
    input wire logic sampleValid,
    // result
    output logic cond,
    output logic [5:0] flags
);
    initial begin
        if (THR_W < 1 || THR_W > 7) $error("threshold width unsupported");
    end

    typedef struct packed {
        logic [5:0] prevDir; // last six-direction pattern
    } det_state_t;
    det_state_t s_q, s_d;

    // magnitude above threshold
    function automatic logic above(input logic signed [7:0] a, input logic [THR_W-1:0] t);
        logic [8:0] mag;
        mag = a[7] ? 9'(-$signed({a[7], a})) : 9'({1'b0, a});
        above = mag > 9'(t);
    endfunction

    // magnitude strictly under threshold, equality is neither event
    function automatic logic below(input logic signed [7:0] a, input logic [THR_W-1:0] t);
        logic [8:0] mag;
        mag = a[7] ? 9'(-$signed({a[7], a})) : 9'({1'b0, a});
        below = mag < 9'(t);
    endfunction

    // signed position beyond threshold either way
    function automatic logic [1:0] dirOf(input logic signed [7:0] a, input logic [THR_W-1:0] t);
        logic signed [8:0] v;
        v = {a[7], a};
        dirOf = {v > $signed({2'b00, t}), v < -$signed({2'b00, t})};
    endfunction

    logic [1:0] mode;
    logic [5:0] mag, dir;
    assign mode = {cfg.andOrCombine, cfg.sixDirectionEnable};

    // per-event evaluation
    always_comb begin
        mag = {above(sample.z, threshold), below(sample.z, threshold),
               above(sample.y, threshold), below(sample.y, threshold),
               above(sample.x, threshold), below(sample.x, threshold)};
        dir = {dirOf(sample.z, threshold), dirOf(sample.y, threshold),
               dirOf(sample.x, threshold)};
        s_d = s_q;
        flags = cfg.enables & (mode[0] ? dir : mag);
        unique case (mode)
            MODE_OR: cond = |flags;
            MODE_AND: cond = (cfg.enables != FLAGS_NONE) && (flags == cfg.enables);
            // movement fires only when the direction pattern changes
            MODE_MOVE: cond = (|flags) && (flags != s_q.prevDir);
            MODE_POS: cond = |flags;
        endcase
        if (sampleValid) begin
            s_d.prevDir = flags;
        end
    end

    // state register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_and_all_needed: assert property (
        (mode == MODE_AND && cond) |-> (flags == cfg.enables))
        else $error("and mode fired without every enabled event");
    a_high_event: assert property (
        (mode == MODE_OR && cfg.enables[1] && above(sample.x, threshold)) |-> cond)
        else $error("x above event not raised");
    a_low_event: assert property (
        (mode == MODE_OR && cfg.enables[4] && below(sample.z, threshold)) |-> cond)
        else $error("z below event not raised");
endmodule

// ==== src/duration_timer.sv ====
`timescale 1ns/1ps
module duration_timer
    import accel_irq_pkg::*;
#(
    parameter int DUR_W = 7
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // sample timing and condition
    input wire logic sampleValid,
    input wire logic cond,
    input wire logic [DUR_W-1:0] minDuration,
    // recognised event, valid with sampleValid
    output logic hit
);
    initial begin
        if (DUR_W < 1 || DUR_W > 7) $error("duration width unsupported");
    end

    typedef struct packed {
        logic [DUR_W-1:0] count; // consecutive true samples so far
    } tmr_state_t;
    tmr_state_t s_q, s_d;

    // counts saturate so a long event stays recognised
    always_comb begin
        s_d = s_q;
        hit = sampleValid && cond && (s_q.count >= minDuration);
        if (sampleValid) begin
            if (!cond) begin
                s_d.count = '0;
            end else if (s_q.count != '1) begin
                s_d.count = s_q.count + 1'b1;
            end
        end
    end

    // state register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_restart_drop: assert property (
        (sampleValid && !cond) |=> (s_q.count == '0))
        else $error("duration count did not restart");
    a_dur_reached: assert property (
        (sampleValid && cond && minDuration == '0) |-> hit)
        else $error("zero duration event not recognised");
endmodule

// ==== src/accel_motion_interrupt_gen.sv ====
`timescale 1ns/1ps
module accel_motion_interrupt_gen
    import accel_irq_pkg::*;
#(
    parameter int THR_W = 7,
    parameter int DUR_W = 7
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // register port
    input wire reg_req_t regReq,
    output logic [7:0] regRdData,
    // acceleration samples at the output rate
    input wire accel_sample_t sample,
    input wire logic sampleValid,
    // control bits held outside this block
    input wire logic latchRequestGen1,
    input wire logic latchRequestGen2,
    input wire logic [1:0] pad1SignalSelect,
    input wire logic [1:0] pad2SignalSelect,
    input wire logic dataReady,
    input wire logic bootRunning,
    // interrupt pads, push-pull
    output logic int1Pin,
    output logic int2Pin
);
    initial begin
        if (THR_W != 7 || DUR_W != 7) $error("register fields are seven bits wide");
    end

    // whole register state of the block
    typedef struct packed {
        event_config_t [NUM_GEN-1:0] cfg;
        logic [NUM_GEN-1:0][7:0] thr;
        logic [NUM_GEN-1:0][7:0] dur;
        event_source_t [NUM_GEN-1:0] src;
        logic [7:0] rdData;
        logic [NUM_GEN-1:0] pin;
    } main_state_t;
    main_state_t s_q, s_d;

    // address decode shared by read and write paths
    function automatic logic [2:0] slotOf(input logic [7:0] a);
        slotOf = 3'(a - ADDR_CFG1);
    endfunction
    function automatic logic mapped(input logic [7:0] a);
        mapped = (a >= ADDR_CFG1) && (a <= ADDR_DUR2);
    endfunction

    logic [NUM_GEN-1:0] latch; // per generator latch choice
    logic [NUM_GEN-1:0] srcRead; // host read of that source this cycle
    logic [NUM_GEN-1:0] cond; // raw event condition
    logic [NUM_GEN-1:0] hit; // condition lasted long enough
    logic [NUM_GEN-1:0][5:0] flags; // enabled events seen now
    logic [NUM_GEN-1:0][1:0] padSel;
    logic [7:0] srcAddr [NUM_GEN];

    // per generator controls gathered as vectors
    assign latch = {latchRequestGen2, latchRequestGen1};
    assign padSel = {pad2SignalSelect, pad1SignalSelect};
    // source addresses indexed by generator
    assign srcAddr[0] = ADDR_SRC1;
    assign srcAddr[1] = ADDR_SRC2;

    // one detector and timer per generator, both alike
    for (genvar g = 0; g < NUM_GEN; g++) begin : gen_unit
        assign srcRead[g] = regReq.rdEn && (regReq.addr == srcAddr[g]);

        event_detect #(
            .THR_W(THR_W)
        ) u_detect (
            .clk(clk),
            .rst_n(rst_n),
            .cfg(s_q.cfg[g]),
            .threshold(s_q.thr[g][THR_W-1:0]),
            .sample(sample),
            .sampleValid(sampleValid),
            .cond(cond[g]),
            .flags(flags[g])
        );

        duration_timer #(
            .DUR_W(DUR_W)
        ) u_timer (
            .clk(clk),
            .rst_n(rst_n),
            .sampleValid(sampleValid),
            .cond(cond[g]),
            .minDuration(s_q.dur[g][DUR_W-1:0]),
            .hit(hit[g])
        );
    end

    // next-state logic for registers, sources and pads
    always_comb begin
        event_source_t fresh;
        logic [2:0] slot;
        fresh = '0;
        slot = slotOf(regReq.addr);
        s_d = s_q;

        // host writes; source registers ignore them
        if (regReq.wrEn && mapped(regReq.addr)) begin
            unique case (regReq.addr)
                ADDR_CFG1: s_d.cfg[0] = regReq.wrData;
                ADDR_CFG2: s_d.cfg[1] = regReq.wrData;
                // top bit of threshold and duration stays zero
                ADDR_THS1: s_d.thr[0] = {1'b0, regReq.wrData[6:0]};
                ADDR_THS2: s_d.thr[1] = {1'b0, regReq.wrData[6:0]};
                ADDR_DUR1: s_d.dur[0] = {1'b0, regReq.wrData[6:0]};
                ADDR_DUR2: s_d.dur[1] = {1'b0, regReq.wrData[6:0]};
                // source addresses fall through untouched
                default: ;
            endcase
        end

        // host reads return the value before any clear
        if (regReq.rdEn) begin
            if (!mapped(regReq.addr)) begin
                // holes read as the filler byte
                s_d.rdData = READ_UNMAPPED;
            end else begin
                // low slot bits pick the register, top bit the unit
                unique case (slot[1:0])
                    2'h0: s_d.rdData = s_q.cfg[slot[2]];
                    2'h1: s_d.rdData = s_q.src[slot[2]];
                    2'h2: s_d.rdData = s_q.thr[slot[2]];
                    2'h3: s_d.rdData = s_q.dur[slot[2]];
                endcase
            end
        end

        // source update per generator
        for (int g = 0; g < NUM_GEN; g++) begin
            // image of the source as this sample would set it
            fresh.zero = 1'b0;
            fresh.eventActiveFlag = hit[g];
            fresh.flags = hit[g] ? flags[g] : FLAGS_NONE;
            if (srcRead[g]) begin
                // read empties the source and releases the pad,
                // so no stale axis flag sits beside a cleared active flag
                s_d.src[g] = '0;
            end
            if (sampleValid) begin
                // a held source only refreshes after its read
                if (!(latch[g] && s_q.src[g].eventActiveFlag && !srcRead[g])) begin
                    // a new sample in the read cycle wins over the clear
                    s_d.src[g] = fresh;
                end
            end
        end

        // pad routing from the registered sources
        for (int g = 0; g < NUM_GEN; g++) begin
            // registered, so a pad trails its source by one cycle
            unique case (padSel[g])
                PAD_OWN: s_d.pin[g] = s_q.src[g].eventActiveFlag;
                PAD_EITHER: s_d.pin[g] = s_q.src[0].eventActiveFlag
                                      || s_q.src[1].eventActiveFlag;
                PAD_DRDY: s_d.pin[g] = dataReady;
                PAD_BOOT: s_d.pin[g] = bootRunning;
            endcase
        end
    end

    // all registers reset to zero
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // outputs straight from flops
    assign regRdData = s_q.rdData;
    assign int1Pin = s_q.pin[0];
    assign int2Pin = s_q.pin[1];

    // every check runs on the one clock
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // host touches a source without a sample arriving
    sequence s_src1_read;
        srcRead[0] && !sampleValid;
    endsequence
    sequence s_src2_read;
        srcRead[1] && !sampleValid;
    endsequence
    sequence s_src1_write;
        regReq.wrEn && regReq.addr == ADDR_SRC1 && !regReq.rdEn && !sampleValid;
    endsequence
    sequence s_src2_write;
        regReq.wrEn && regReq.addr == ADDR_SRC2 && !regReq.rdEn && !sampleValid;
    endsequence

    // first source ignores host writes
    a_src_readonly: assert property (
        s_src1_write |=> (s_q.src[0] == $past(s_q.src[0])))
        else $error("write altered first source");
    // first pad drops after its read
    a_read_clear1: assert property (
        s_src1_read ##1 (padSel[0] == PAD_OWN) |=> !int1Pin)
        else $error("first pad not released after read");
    // second flag gone after its read
    a_read_clear2: assert property (
        s_src2_read |=> !s_q.src[1].eventActiveFlag)
        else $error("second active flag not cleared");
    // held first source waits for its read
    a_latch_hold: assert property (
        (latch[0] && s_q.src[0].eventActiveFlag && !srcRead[0])
        |=> (s_q.src[0] == $past(s_q.src[0])))
        else $error("latched source changed before read");
    // live second source tracks each sample
    a_live_follow: assert property (
        (!latch[1] && sampleValid) |=> (s_q.src[1].eventActiveFlag == $past(hit[1])))
        else $error("unlatched source did not follow condition");
    // threshold write keeps seven bits only
    a_thr_top_zero: assert property (
        (regReq.wrEn && regReq.addr == ADDR_THS1)
        |=> (s_q.thr[0] == {1'b0, $past(regReq.wrData[6:0])}))
        else $error("threshold write not stored as seven bits");
    // second pad as OR of both sources
    a_pad_either: assert property (
        (pad2SignalSelect == PAD_EITHER) |=> (int2Pin == $past(
            s_q.src[0].eventActiveFlag || s_q.src[1].eventActiveFlag)))
        else $error("second pad not the OR of sources");
    // no first axis flag without its active flag
    a_flags_active: assert property (
        (s_q.src[0].flags != FLAGS_NONE) |-> s_q.src[0].eventActiveFlag)
        else $error("axis flag without active flag");
    // second source ignores host writes
    a_src2_readonly: assert property (
        s_src2_write |=> (s_q.src[1] == $past(s_q.src[1])))
        else $error("write altered second source");
    // first flag gone after its read
    a_read_flag1: assert property (
        s_src1_read |=> !s_q.src[0].eventActiveFlag)
        else $error("first active flag not cleared");
    // second pad drops after its read
    a_read_pad2: assert property (
        s_src2_read ##1 (padSel[1] == PAD_OWN) |=> !int2Pin)
        else $error("second pad not released after read");
    // a read returns the first source before the clear
    a_read_data1: assert property (
        s_src1_read |=> (regRdData == $past(s_q.src[0])))
        else $error("first source read data wrong");
    // same for the second source
    a_read_data2: assert property (
        s_src2_read |=> (regRdData == $past(s_q.src[1])))
        else $error("second source read data wrong");
    // held second source waits for its read
    a_latch_hold2: assert property (
        (latch[1] && s_q.src[1].eventActiveFlag && !srcRead[1])
        |=> (s_q.src[1] == $past(s_q.src[1])))
        else $error("latched second source changed before read");
    // live first source tracks each sample
    a_live_follow1: assert property (
        (!latch[0] && sampleValid) |=> (s_q.src[0].eventActiveFlag == $past(hit[0])))
        else $error("unlatched first source did not follow condition");
    // a recognised event raises the active flag
    a_hit_active1: assert property (
        (sampleValid && hit[0]) |=> s_q.src[0].eventActiveFlag)
        else $error("first active flag missed an event");
    // same for the second unit
    a_hit_active2: assert property (
        (sampleValid && hit[1]) |=> s_q.src[1].eventActiveFlag)
        else $error("second active flag missed an event");
    // first pad on its own source
    a_pad_own1: assert property (
        (padSel[0] == PAD_OWN) |=> (int1Pin == $past(s_q.src[0].eventActiveFlag)))
        else $error("first pad not its own source");
    // first pad as OR of both sources
    a_pad_either1: assert property (
        (padSel[0] == PAD_EITHER) |=> (int1Pin == $past(
            s_q.src[0].eventActiveFlag || s_q.src[1].eventActiveFlag)))
        else $error("first pad not the OR of sources");
    // first pad on data ready
    a_pad_ready: assert property (
        (padSel[0] == PAD_DRDY) |=> (int1Pin == $past(dataReady)))
        else $error("first pad not data ready");
    // second pad on boot running
    a_pad_boot: assert property (
        (padSel[1] == PAD_BOOT) |=> (int2Pin == $past(bootRunning)))
        else $error("second pad not boot running");
    // no second axis flag without its active flag
    a_flags_active2: assert property (
        (s_q.src[1].flags != FLAGS_NONE) |-> s_q.src[1].eventActiveFlag)
        else $error("second axis flag without active flag");
    // duration write keeps seven bits only
    a_dur_top_zero: assert property (
        (regReq.wrEn && regReq.addr == ADDR_DUR1)
        |=> (s_q.dur[0] == {1'b0, $past(regReq.wrData[6:0])}))
        else $error("duration write not stored as seven bits");
    // second threshold stored like the first
    a_thr2_write: assert property (
        (regReq.wrEn && regReq.addr == ADDR_THS2)
        |=> (s_q.thr[1] == {1'b0, $past(regReq.wrData[6:0])}))
        else $error("second threshold write not stored");
    // second configuration stored whole
    a_cfg2_write: assert property (
        (regReq.wrEn && regReq.addr == ADDR_CFG2) |=> (s_q.cfg[1] == $past(regReq.wrData)))
        else $error("second configuration write not stored");
endmodule

// ==== bench/host_model.sv ====
`timescale 1ns/1ps
// host side of the register port, strobes move just after a rising edge
module host_model
    import accel_irq_pkg::*;
(
    // clock
    input wire logic clk,
    // register port
    output reg_req_t regReq,
    input wire logic [7:0] regRdData,
    // pads seen by the host
    input wire logic int1Pin,
    input wire logic int2Pin
);
    // idle port at time zero
    initial regReq = '0;

    // single byte write, strobe held one cycle
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        regReq <= '{1'b1, 1'b0, a, d};
        @(posedge clk);
        // released lines show the inverse, not the stale value
        regReq <= '{1'b0, 1'b0, ~a, ~d};
    endtask

    // single byte read, data taken once the answer edge has landed
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        regReq <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge clk);
        regReq <= '{1'b0, 1'b0, ~a, 8'hFF};
        #1;
        d = regRdData;
    endtask

    // wait (bounded) for a pad, then read the source so the pad drops
    task automatic service(input logic [7:0] a, output logic [7:0] d);
        int n;
        n = 0;
        while (int1Pin !== 1'b1 && int2Pin !== 1'b1 && n < 64) begin
            @(posedge clk);
            n++;
        end
        rd(a, d);
    endtask
endmodule

// ==== bench/test_accel_motion_interrupt_gen.sv ====
`timescale 1ns/1ps
// top of the bench: host model on the register port, samples driven here
module test_accel_motion_interrupt_gen
    import accel_irq_pkg::*;
;
    logic clk;
    logic rst_n;
    reg_req_t regReq;
    logic [7:0] regRdData;
    accel_sample_t sample;
    logic sampleValid;
    logic latchRequestGen1;
    logic latchRequestGen2;
    logic [1:0] pad1SignalSelect;
    logic [1:0] pad2SignalSelect;
    logic dataReady;
    logic bootRunning;
    logic int1Pin;
    logic int2Pin;
    int mismatches = 0;
    int n_tests = 0;

    accel_motion_interrupt_gen dut (
        .clk(clk), .rst_n(rst_n), .regReq(regReq), .regRdData(regRdData),
        .sample(sample), .sampleValid(sampleValid),
        .latchRequestGen1(latchRequestGen1), .latchRequestGen2(latchRequestGen2),
        .pad1SignalSelect(pad1SignalSelect), .pad2SignalSelect(pad2SignalSelect),
        .dataReady(dataReady), .bootRunning(bootRunning),
        .int1Pin(int1Pin), .int2Pin(int2Pin)
    );

    host_model host (
        .clk(clk), .regReq(regReq), .regRdData(regRdData),
        .int1Pin(int1Pin), .int2Pin(int2Pin)
    );

    // 40 MHz clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // compare and count
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // both pads at once, {int2, int1}
    task automatic pins(input logic [1:0] e);
        chk({6'h00, int2Pin, int1Pin}, {6'h00, e});
    endtask

    // read a register and compare
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        host.rd(a, d);
        chk(d, e);
    endtask

    // one sample pulse; returns once source and pads have settled
    task automatic smp(input logic signed [7:0] x, y, z);
        @(posedge clk);
        sample <= '{z, y, x};
        sampleValid <= 1'b1;
        @(posedge clk);
        sampleValid <= 1'b0;
        @(posedge clk);
        #1;
    endtask

    // pads are registered, give them two edges
    task automatic settle();
        repeat (2) @(posedge clk);
        #1;
    endtask

    // one mode case on the first generator
    task automatic mcase(input logic [7:0] c, input logic signed [7:0] x, y, z,
                         input logic [7:0] e);
        host.wr(ADDR_CFG1, c);
        smp(x, y, z);
        rchk(ADDR_SRC1, e);
    endtask

    // reset values of the whole map and an unmapped hole
    task automatic t_reset();
        for (int i = 0; i < 8; i++) begin
            rchk(ADDR_CFG1 + 8'(i), REG_RESET);
        end
        rchk(8'h40, READ_UNMAPPED);
        pins(2'b00);
        $display("t_reset done");
    endtask

    // field widths and read-only sources
    task automatic t_regs();
        host.wr(ADDR_THS1, 8'hFF);
        rchk(ADDR_THS1, 8'h7F);
        host.wr(ADDR_DUR1, 8'hFF);
        rchk(ADDR_DUR1, 8'h7F);
        host.wr(ADDR_SRC1, 8'hFF);
        rchk(ADDR_SRC1, 8'h00);
        host.wr(ADDR_SRC2, 8'hFF);
        rchk(ADDR_SRC2, 8'h00);
        host.wr(ADDR_CFG2, 8'hA5);
        rchk(ADDR_CFG2, 8'hA5);
        host.wr(ADDR_CFG2, 8'h00);
        host.wr(ADDR_DUR1, 8'h00);
        host.wr(ADDR_THS1, 8'h0A);
        $display("t_regs done");
    endtask

    // every mode, threshold 10
    task automatic t_modes();
        mcase(8'h02, -20, 0, 0, 8'h42);
        mcase(8'h01, 5, 0, 0, 8'h41);
        mcase(8'h01, 20, 0, 0, 8'h00);
        mcase(8'h03, 10, 0, 0, 8'h00);
        mcase(8'h0A, 20, 5, 0, 8'h42);
        mcase(8'h8A, 20, 5, 0, 8'h00);
        mcase(8'h8A, 20, 20, 0, 8'h4A);
        mcase(8'hFF, 0, 0, 30, 8'h60);
        mcase(8'hFF, 0, 0, 30, 8'h60);
        mcase(8'h7F, 0, 0, -30, 8'h50);
        mcase(8'h7F, 0, 0, -30, 8'h00);
        $display("t_modes done");
    endtask

    // latched source frozen until read, pad dropped by the read
    task automatic t_latch();
        logic [7:0] d;
        @(posedge clk) latchRequestGen1 <= 1'b1;
        host.wr(ADDR_CFG1, 8'h02);
        smp(20, 0, 0);
        pins(2'b01);
        smp(0, 0, 0);
        host.service(ADDR_SRC1, d);
        chk(d, 8'h42);
        settle();
        pins(2'b00);
        rchk(ADDR_SRC1, 8'h00);
        smp(0, 0, 0);
        rchk(ADDR_SRC1, 8'h00);
        @(posedge clk) latchRequestGen1 <= 1'b0;
        smp(20, 0, 0);
        smp(0, 0, 0);
        rchk(ADDR_SRC1, 8'h00);
        $display("t_latch done");
    endtask

    // minimum duration 3, restart on a drop
    task automatic t_dur();
        host.wr(ADDR_DUR1, 8'h03);
        repeat (3) smp(20, 0, 0);
        rchk(ADDR_SRC1, 8'h00);
        smp(0, 0, 0);
        repeat (3) smp(20, 0, 0);
        rchk(ADDR_SRC1, 8'h00);
        smp(20, 0, 0);
        rchk(ADDR_SRC1, 8'h42);
        $display("t_dur done");
    endtask

    // second generator alone, then pad routing
    task automatic t_gen2();
        host.wr(ADDR_CFG1, 8'h00);
        host.wr(ADDR_CFG2, 8'h02);
        host.wr(ADDR_THS2, 8'h0A);
        smp(20, 0, 0);
        pins(2'b10);
        rchk(ADDR_SRC1, 8'h00);
        @(posedge clk) begin
            pad1SignalSelect <= PAD_EITHER;
            pad2SignalSelect <= PAD_EITHER;
        end
        settle();
        pins(2'b11);
        rchk(ADDR_SRC2, 8'h42);
        settle();
        pins(2'b00);
        @(posedge clk) begin
            pad1SignalSelect <= PAD_DRDY;
            dataReady <= 1'b1;
        end
        settle();
        pins(2'b01);
        @(posedge clk) begin
            pad2SignalSelect <= PAD_BOOT;
            bootRunning <= 1'b1;
            dataReady <= 1'b0;
        end
        settle();
        pins(2'b10);
        @(posedge clk) latchRequestGen2 <= 1'b1;
        smp(20, 0, 0);
        smp(0, 0, 0);
        rchk(ADDR_SRC2, 8'h42);
        $display("t_gen2 done");
    endtask

    // counts, verdict, stop
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // watchdog, far beyond the few hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        end_of_test();
    end

    // main sequence
    initial begin
        rst_n = 1'b0;
        sample = '0;
        sampleValid = 1'b0;
        latchRequestGen1 = 1'b0;
        latchRequestGen2 = 1'b0;
        pad1SignalSelect = PAD_OWN;
        pad2SignalSelect = PAD_OWN;
        dataReady = 1'b0;
        bootRunning = 1'b0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_regs();
        t_modes();
        t_latch();
        t_dur();
        t_gen2();
        end_of_test();
    end
endmodule
